// *** core/ciaer_regs.sv ***
// Purpose: subsystem identity, indirect config window, error capability header,
//          uncorrectable error flags and masks
// Assumes: one config access port, single-cycle access, data out one cycle later
// Notes:
// Summary of operation
// - subsystem maker code, bits 15:0, lockable read-write, resets zero
// - subsystem product code, bits 31:16, lockable read-write, resets zero
// - index register: dword index 7:2, extended index 11:8, read-write
// - window read returns register selected by the index
// - window write updates register selected by the index
// - indirect access uses the window access byte enables
// - index pointing at window: reads zero, writes discarded
// - index pointing at index register: window write changes index
// - window access from serial management port: reads zero, writes ignored
// - capability header: code 0x1 bits 15:0, version 0x1 bits 19:16
// - link protocol fault sets sticky clear-on-one bit 4
// - surprise down sets bit 5, only when reporting capable
// - poisoned packet sets sticky bit 12
// - flow credit fault sets sticky bit 13
// - completion timeout bit 14 hardwired zero
// - completer abort bit 15 reads zero, read-only
// - unexpected completion sets sticky bit 16
// - receiver overflow sets sticky bit 17
// - malformed packet sets sticky bit 18
// - end-to-end crc error sets sticky bit 19
// - unsupported request sets sticky bit 20
// - bit 0 unused, sticky, clearable in flags, writable in masks
// - masked events are neither logged nor reported
`timescale 1ns/100ps
`include "ciaer_defs.svh"

module ciaer_regs (
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic        por_n,
   input  wire logic        cfg_req,
   input  wire logic        cfg_wr,
   input  wire logic        cfg_smbus,
   input  wire logic [11:0] cfg_addr,
   input  wire logic [3:0]  cfg_be,
   input  wire logic [31:0] cfg_wdata,
   output logic      [31:0] cfg_rdata,
   output logic             cfg_rvalid,
   input  wire logic        id_lock_n,
   input  wire logic        surprise_down_report_capable,
   input  wire logic        link_protocol_fault,
   input  wire logic        surprise_down_fault,
   input  wire logic        poisoned_packet,
   input  wire logic        flow_credit_fault,
   input  wire logic        unexpected_completion,
   input  wire logic        receiver_overflow,
   input  wire logic        bad_format_packet,
   input  wire logic        ecrc_fault,
   input  wire logic        unsupported_request,
   output logic      [31:0] ue_unmasked_events,
   output logic      [31:0] ue_flags
);

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  be);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [31:0] be_mask(input logic [3:0] be);
      return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // state

   ciaer_pkg::ciaer_state_type state_ff;
   ciaer_pkg::ciaer_state_type nxt_state;
   ciaer_pkg::ciaer_state_type sticky_ff;
   ciaer_pkg::ciaer_state_type nxt_sticky;

   logic [31:0] events;
   logic [11:0] index_addr;
   logic        win_hit;
   logic [11:0] tgt_addr;
   logic [3:0]  tgt_be;
   logic        tgt_wr;
   logic [31:0] tgt_rdata;
   logic        tgt_hit;
   logic [31:0] merged;

   always_comb begin
      events = 32'h0000_0000;
      events[`CIAER_BIT_LINK]  = link_protocol_fault;
      events[`CIAER_BIT_SDOWN] = surprise_down_fault & surprise_down_report_capable;
      events[`CIAER_BIT_POISON] = poisoned_packet;
      events[`CIAER_BIT_FLOWC] = flow_credit_fault;
      events[`CIAER_BIT_UNEXP] = unexpected_completion;
      events[`CIAER_BIT_OVFL]  = receiver_overflow;
      events[`CIAER_BIT_MALF]  = bad_format_packet;
      events[`CIAER_BIT_ECRC]  = ecrc_fault;
      events[`CIAER_BIT_UREQ]  = unsupported_request;
   end

   // index register contents as a byte address
   assign index_addr = {state_ff.extended_index, state_ff.dword_index, 2'b00};
   assign win_hit    = cfg_req && (cfg_addr == `CIAER_OFF_WINDOW);

   // indirect redirect: the window access lands on the indexed register
   always_comb begin
      tgt_addr = cfg_addr;
      tgt_be   = cfg_be;
      tgt_wr   = cfg_req & cfg_wr;
      if (win_hit) begin
         tgt_addr = index_addr;
         if (cfg_smbus || index_addr == `CIAER_OFF_WINDOW) begin
            tgt_wr = 1'b0;
         end
      end
   end

   // read mux, reserved bits zero
   always_comb begin
      tgt_hit = 1'b1;
      case (tgt_addr)
         `CIAER_OFF_SUBSYS: tgt_rdata = {state_ff.product_code, state_ff.maker_code};
         `CIAER_OFF_INDEX:  tgt_rdata = {20'h00000, index_addr};
         `CIAER_OFF_CAPHDR: tgt_rdata = {state_ff.nxt_cap_ptr, `CIAER_CAP_VER,
                                         `CIAER_CAP_CODE};
         `CIAER_OFF_UESTAT: tgt_rdata = sticky_ff.ue_flags & `CIAER_UE_STAT_MASK;
         `CIAER_OFF_UEMASK: tgt_rdata = sticky_ff.ue_masks & `CIAER_UE_MASK_MASK;
         default: begin
            tgt_rdata = 32'h0000_0000;
            tgt_hit   = 1'b0;
         end
      endcase
      if (win_hit && (cfg_smbus || index_addr == `CIAER_OFF_WINDOW)) begin
         tgt_rdata = 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      nxt_state  = state_ff;
      nxt_sticky = sticky_ff;
      merged     = 32'h0000_0000;
      nxt_state.rvalid = cfg_req & ~cfg_wr;
      nxt_state.rdata  = (cfg_req & ~cfg_wr) ? tgt_rdata : state_ff.rdata;
      if (tgt_wr) begin
         case (tgt_addr)
            `CIAER_OFF_SUBSYS: begin
               if (!id_lock_n) begin
               end else begin
                  {nxt_state.product_code, nxt_state.maker_code} =
                     be_merge({state_ff.product_code, state_ff.maker_code},
                              cfg_wdata, tgt_be);
               end
            end
            `CIAER_OFF_INDEX: begin
               merged = be_merge({20'h00000, index_addr}, cfg_wdata, tgt_be);
               {nxt_state.extended_index, nxt_state.dword_index} = merged[11:2];
            end
            `CIAER_OFF_CAPHDR: begin
               if (id_lock_n) begin
                  merged = be_merge({state_ff.nxt_cap_ptr, 20'h00000}, cfg_wdata, tgt_be);
                  nxt_state.nxt_cap_ptr = merged[31:20];
               end
            end
            `CIAER_OFF_UESTAT: begin
               nxt_sticky.ue_flags = sticky_ff.ue_flags
                  & ~(cfg_wdata & be_mask(tgt_be) & `CIAER_UE_STAT_MASK);
            end
            `CIAER_OFF_UEMASK: begin
               nxt_sticky.ue_masks =
                  be_merge(sticky_ff.ue_masks, cfg_wdata, tgt_be) & `CIAER_UE_MASK_MASK;
            end
            default: begin
            end
         endcase
      end
      // set wins over clear, masked events not logged
      nxt_sticky.ue_flags = (nxt_sticky.ue_flags | (events & ~sticky_ff.ue_masks))
                            & `CIAER_UE_STAT_MASK;
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers: ordinary reset, and power-on only for sticky fields

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff             <= '0;
         state_ff.nxt_cap_ptr <= `CIAER_NEXT_CAPABILITY_POINTER_RST;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge core_clk or negedge por_n) begin
      if (!por_n) begin
         sticky_ff <= '0;
      end else begin
         sticky_ff <= nxt_sticky;
      end
   end

   assign cfg_rdata          = state_ff.rdata;
   assign cfg_rvalid         = state_ff.rvalid;
   assign ue_flags           = sticky_ff.ue_flags;
   assign ue_unmasked_events = events & ~sticky_ff.ue_masks;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   a_sticky_set_wins: assert property (@(posedge core_clk) disable iff (!por_n)
      (events[`CIAER_BIT_LINK] && !sticky_ff.ue_masks[`CIAER_BIT_LINK])
      |=> ue_flags[`CIAER_BIT_LINK]) else $error("link fault not logged");
   a_sdown_gated: assert property (@(posedge core_clk) disable iff (!por_n)
      (!surprise_down_report_capable && !ue_flags[`CIAER_BIT_SDOWN])
      |=> !ue_flags[`CIAER_BIT_SDOWN]) else $error("surprise down set while incapable");
   a_hardwired_zero: assert property (@(posedge core_clk) disable iff (!por_n)
      !ue_flags[`CIAER_BIT_CTO] && !ue_flags[`CIAER_BIT_CABT]) else $error("bit 14/15 set");
   a_masked_not_logged: assert property (@(posedge core_clk) disable iff (!por_n)
      (sticky_ff.ue_masks[`CIAER_BIT_UREQ] && !ue_flags[`CIAER_BIT_UREQ])
      |=> !ue_flags[`CIAER_BIT_UREQ]) else $error("masked event logged");
   a_clear_one: assert property (@(posedge core_clk) disable iff (!por_n || !rst_n)
      (cfg_req && cfg_wr && !cfg_smbus && cfg_addr == `CIAER_OFF_UESTAT && cfg_be[2]
       && cfg_wdata[`CIAER_BIT_MALF] && !bad_format_packet)
      |=> !ue_flags[`CIAER_BIT_MALF]) else $error("flag not cleared");
   a_event_beats_clear: assert property (@(posedge core_clk) disable iff (!por_n)
      (poisoned_packet && !sticky_ff.ue_masks[`CIAER_BIT_POISON])
      |=> ue_flags[`CIAER_BIT_POISON]) else $error("event lost on clear");
   a_cap_header: assert property (@(posedge core_clk) disable iff (!rst_n)
      (cfg_req && !cfg_wr && !cfg_smbus && cfg_addr == `CIAER_OFF_CAPHDR)
      |=> cfg_rvalid && cfg_rdata[19:0] == 20'h10001) else $error("bad cap header");
   a_window_smbus: assert property (@(posedge core_clk) disable iff (!rst_n)
      (cfg_req && !cfg_wr && cfg_smbus && cfg_addr == `CIAER_OFF_WINDOW)
      |=> cfg_rdata == 32'h0000_0000) else $error("smbus window read nonzero");
   a_window_self: assert property (@(posedge core_clk) disable iff (!rst_n)
      (cfg_req && !cfg_wr && cfg_addr == `CIAER_OFF_WINDOW
       && index_addr == `CIAER_OFF_WINDOW)
      |=> cfg_rdata == 32'h0000_0000) else $error("self window read nonzero");
   a_index_stable: assert property (@(posedge core_clk) disable iff (!rst_n)
      !(cfg_req && cfg_wr) |=> $stable(index_addr)) else $error("index moved");
   a_window_read: assert property (@(posedge core_clk) disable iff (!rst_n || !por_n)
      (cfg_req && !cfg_wr && !cfg_smbus && cfg_addr == `CIAER_OFF_WINDOW
       && index_addr == `CIAER_OFF_UEMASK)
      |=> cfg_rdata == $past(sticky_ff.ue_masks)) else $error("window read wrong");

endmodule

// *** shared/ciaer_defs.svh ***
// Purpose: offsets, field positions, reset values of the config register group
// Assumes: byte addresses on the configuration access port
// Notes:   included by the core and the bench
`ifndef CIAER_DEFS_SVH
`define CIAER_DEFS_SVH
`define CIAER_OFF_SUBSYS        12'h0f4
`define CIAER_OFF_INDEX         12'h0f8
`define CIAER_OFF_WINDOW        12'h0fc
`define CIAER_OFF_CAPHDR        12'h100
`define CIAER_OFF_UESTAT        12'h104
`define CIAER_OFF_UEMASK        12'h108
`define CIAER_SUBSYS_RST        32'h0000_0000
`define CIAER_INDEX_RST         32'h0000_0000
`define CIAER_INDEX_WMASK       32'h0000_0ffc
`define CIAER_CAP_CODE          16'h0001
`define CIAER_CAP_VER           4'h1
`define CIAER_NEXT_CAPABILITY_POINTER_RST        12'h200
`define CIAER_UE_RST            32'h0000_0000
`define CIAER_UE_STAT_MASK      32'h001f_3031
`define CIAER_UE_MASK_MASK      32'h001f_3031
`define CIAER_BIT_UNUSED        0
`define CIAER_BIT_LINK          4
`define CIAER_BIT_SDOWN         5
`define CIAER_BIT_POISON        12
`define CIAER_BIT_FLOWC         13
`define CIAER_BIT_CTO           14
`define CIAER_BIT_CABT          15
`define CIAER_BIT_UNEXP         16
`define CIAER_BIT_OVFL          17
`define CIAER_BIT_MALF          18
`define CIAER_BIT_ECRC          19
`define CIAER_BIT_UREQ          20
`endif

// *** shared/ciaer_pkg.sv ***
// Purpose: types of the config register group
// Assumes: constants live in ciaer_defs.svh
// Notes:   no imports; use ciaer_pkg::name
package ciaer_pkg;
   typedef struct packed {
      logic [15:0] maker_code;
      logic [15:0] product_code;
      logic [5:0]  dword_index;
      logic [3:0]  extended_index;
      logic [11:0] nxt_cap_ptr;
      logic [31:0] ue_flags;
      logic [31:0] ue_masks;
      logic [31:0] rdata;
      logic        rvalid;
   } ciaer_state_type;
endpackage

// *** dv/ciaer_tb.sv ***
// Purpose: self-checking bench of the config register group
// Assumes: inputs driven at the falling edge, read data one cycle after the request
// Notes:   assertions live in the design files
`timescale 1ns/100ps
`include "ciaer_defs.svh"
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin err_count++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); end end

module testbench;
   logic        core_clk = 1'b0;
   logic        rst_n    = 1'b0;
   logic        por_n    = 1'b0;
   logic        cfg_req  = 1'b0;
   logic        cfg_wr   = 1'b0;
   logic        cfg_smbus = 1'b0;
   logic [11:0] cfg_addr = 12'h000;
   logic [3:0]  cfg_be   = 4'h0;
   logic [31:0] cfg_wdata = 32'h0000_0000;
   logic [31:0] cfg_rdata;
   logic        cfg_rvalid;
   logic        id_lock_n = 1'b1;
   logic        sd_cap    = 1'b1;
   logic [8:0]  ev        = 9'h000;
   logic [31:0] ue_unmasked_events;
   logic [31:0] ue_flags;
   logic [31:0] rd;
   int          err_count = 0;
   int          n_tests   = 0;
   int          pos [9]   = '{4, 5, 12, 13, 16, 17, 18, 19, 20};

   always #10 core_clk = ~core_clk;

   ciaer_regs i_dut (
      .core_clk(core_clk), .rst_n(rst_n), .por_n(por_n), .cfg_req(cfg_req),
      .cfg_wr(cfg_wr), .cfg_smbus(cfg_smbus), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
      .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
      .id_lock_n(id_lock_n), .surprise_down_report_capable(sd_cap),
      .link_protocol_fault(ev[0]), .surprise_down_fault(ev[1]), .poisoned_packet(ev[2]),
      .flow_credit_fault(ev[3]), .unexpected_completion(ev[4]),
      .receiver_overflow(ev[5]), .bad_format_packet(ev[6]), .ecrc_fault(ev[7]),
      .unsupported_request(ev[8]), .ue_unmasked_events(ue_unmasked_events),
      .ue_flags(ue_flags));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
      @(negedge core_clk);
      {cfg_req, cfg_wr, cfg_addr, cfg_wdata, cfg_be} = {2'b11, a, d, be};
      @(negedge core_clk);
      cfg_req = 1'b0;
   endtask

   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
      @(negedge core_clk);
      {cfg_req, cfg_wr, cfg_addr} = {2'b10, a};
      @(negedge core_clk);
      cfg_req = 1'b0;
      `CHK(cfg_rvalid, 1'b1)
      `CHK(cfg_rdata, exp)
   endtask

   task automatic pulse(input int i);
      @(negedge core_clk);
      ev[i] = 1'b1;
      @(negedge core_clk);
      ev[i] = 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset_values;
      rdchk(`CIAER_OFF_SUBSYS, 32'h0000_0000);
      rdchk(`CIAER_OFF_INDEX, 32'h0000_0000);
      rdchk(`CIAER_OFF_CAPHDR, 32'h2001_0001);
      rdchk(`CIAER_OFF_UESTAT, 32'h0000_0000);
      rdchk(12'h000, 32'h0000_0000);
      $display("test reset values done");
   endtask

   task automatic t_identity;
      wr(`CIAER_OFF_SUBSYS, 32'h1234_5678, 4'hf);
      wr(`CIAER_OFF_CAPHDR, 32'hfffe_eeee, 4'hf);
      rdchk(`CIAER_OFF_CAPHDR, 32'hfff1_0001);
      wr(`CIAER_OFF_INDEX, 32'hffff_ffff, 4'hf);
      rdchk(`CIAER_OFF_INDEX, 32'h0000_0ffc);
      id_lock_n = 1'b0;
      wr(`CIAER_OFF_SUBSYS, 32'h0000_0000, 4'hf);
      rdchk(`CIAER_OFF_SUBSYS, 32'h1234_5678);
      wr(`CIAER_OFF_CAPHDR, 32'h0000_0000, 4'hf);
      rdchk(`CIAER_OFF_CAPHDR, 32'hfff1_0001);
      id_lock_n = 1'b1;
      $display("test identity done");
   endtask

   task automatic t_window;
      wr(`CIAER_OFF_INDEX, 32'h0000_00f4, 4'hf);
      rdchk(`CIAER_OFF_WINDOW, 32'h1234_5678);
      wr(`CIAER_OFF_WINDOW, 32'haaaa_bbbb, 4'hc);
      rdchk(`CIAER_OFF_SUBSYS, 32'haaaa_5678);
      cfg_smbus = 1'b1;
      rdchk(`CIAER_OFF_WINDOW, 32'h0000_0000);
      wr(`CIAER_OFF_WINDOW, 32'h0000_0000, 4'hf);
      cfg_smbus = 1'b0;
      rdchk(`CIAER_OFF_SUBSYS, 32'haaaa_5678);
      wr(`CIAER_OFF_INDEX, 32'h0000_00fc, 4'hf);
      rdchk(`CIAER_OFF_WINDOW, 32'h0000_0000);
      wr(`CIAER_OFF_WINDOW, 32'h0000_00f4, 4'hf);
      rdchk(`CIAER_OFF_INDEX, 32'h0000_00fc);
      wr(`CIAER_OFF_INDEX, 32'h0000_00f8, 4'hf);
      wr(`CIAER_OFF_WINDOW, 32'h0000_0100, 4'h3);
      rdchk(`CIAER_OFF_INDEX, 32'h0000_0100);
      rdchk(`CIAER_OFF_WINDOW, 32'hfff1_0001);
      $display("test window done");
   endtask

   task automatic t_events;
      for (int i = 0; i < 9; i++) begin
         pulse(i);
         `CHK(ue_flags, 32'h1 << pos[i])
         wr(`CIAER_OFF_UESTAT, 32'h0000_0000, 4'hf);
         rdchk(`CIAER_OFF_UESTAT, 32'h1 << pos[i]);
         wr(`CIAER_OFF_UESTAT, ~(32'h1 << pos[i]), 4'hf);
         `CHK(ue_flags, 32'h1 << pos[i])
         wr(`CIAER_OFF_UESTAT, 32'hffff_ffff, 4'hf);
         `CHK(ue_flags, 32'h0000_0000)
      end
      sd_cap = 1'b0;
      pulse(1);
      `CHK(ue_flags, 32'h0000_0000)
      sd_cap = 1'b1;
      @(negedge core_clk);
      {cfg_req, cfg_wr, cfg_addr, cfg_wdata, cfg_be} = {2'b11, 12'h104, 32'h10, 4'hf};
      ev[0] = 1'b1;
      @(negedge core_clk);
      {cfg_req, ev[0]} = 2'b00;
      `CHK(ue_flags, 32'h0000_0010)
      rdchk(`CIAER_OFF_UESTAT, 32'h0000_0010);
      $display("test events done");
   endtask

   task automatic t_masks_resets;
      wr(`CIAER_OFF_UEMASK, 32'hffff_ffff, 4'hf);
      rdchk(`CIAER_OFF_UEMASK, 32'h001f_3031);
      wr(`CIAER_OFF_UESTAT, 32'hffff_ffff, 4'hf);
      @(negedge core_clk);
      ev = 9'h1ff;
      #1 `CHK(ue_unmasked_events, 32'h0000_0000)
      @(negedge core_clk);
      ev = 9'h000;
      `CHK(ue_flags, 32'h0000_0000)
      wr(`CIAER_OFF_UEMASK, 32'h0000_0001, 4'hf);
      wr(`CIAER_OFF_INDEX, 32'h0000_0108, 4'hf);
      rdchk(`CIAER_OFF_WINDOW, 32'h0000_0001);
      pulse(3);
      @(negedge core_clk);
      rst_n = 1'b0;
      @(negedge core_clk);
      rst_n = 1'b1;
      `CHK(ue_flags, 32'h0000_2000)
      rdchk(`CIAER_OFF_UEMASK, 32'h0000_0001);
      rdchk(`CIAER_OFF_SUBSYS, 32'h0000_0000);
      rdchk(`CIAER_OFF_CAPHDR, 32'h2001_0001);
      rdchk(`CIAER_OFF_INDEX, 32'h0000_0000);
      por_n = 1'b0;
      @(negedge core_clk);
      por_n = 1'b1;
      rdchk(`CIAER_OFF_UESTAT, 32'h0000_0000);
      $display("test masks and resets done");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   initial begin
      #100000;
      err_count++;
      test_done;
   end

   initial begin
      repeat (2) @(negedge core_clk);
      {rst_n, por_n} = 2'b11;
      t_reset_values;
      t_identity;
      t_window;
      t_events;
      t_masks_resets;
      test_done;
   end
endmodule
